// >>> design/safc_div.sv
`timescale 1ns/1ps
module safc_div
    import safc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [31:0] divisor,
    output logic             done,
    output logic      [31:0] quotient
);
    logic        run;
    logic [5:0]  steps;
    logic [31:0] rem;
    logic [31:0] dsr;
    wire  [32:0] shifted = {rem, quotient[31]};
    wire  [33:0] diff    = {1'b0, shifted} - {2'h0, dsr};

    // restoring division, one quotient bit per cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            run      <= 1'b0;
            steps    <= 6'h00;
            rem      <= 32'h0;
            dsr      <= 32'h0;
            quotient <= 32'h0;
            done     <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                run      <= 1'b1;
                steps    <= 6'(DIV_STEPS);
                rem      <= 32'h0;
                dsr      <= divisor;
                quotient <= dividend;
            end else if (run) begin
                rem      <= diff[33] ? shifted[31:0] : diff[31:0];
                quotient <= {quotient[30:0], ~diff[33]};
                steps    <= steps - 6'h01;
                if (steps == 6'h01) begin
                    run  <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> design/safc_pkg.sv
package safc_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS    = 4;
    localparam int US_NS            = 1000;
    localparam int CYC_PER_US       = US_NS / CLK_PERIOD_NS;
    localparam int FRAME_MS         = 20;
    localparam int FRAME_CYCLES_DEF = FRAME_MS * 1_000_000 / CLK_PERIOD_NS;

    // feedback period window, nominal frequency plus or minus a tolerance
    localparam int FB_FREQ_HZ       = 910;
    localparam int FB_TOL_PCT       = 5;
    localparam int FB_CYC_DEN       = FB_FREQ_HZ * CLK_PERIOD_NS;
    localparam int FB_MIN_CYC_DEF   = ((100 - FB_TOL_PCT) * 10_000_000 + FB_CYC_DEN - 1)
                                      / FB_CYC_DEN;
    localparam int FB_MAX_CYC_DEF   = ((100 + FB_TOL_PCT) * 10_000_000) / FB_CYC_DEN;

    // angle conversion
    localparam int DUTY_SCALE       = 1000;
    localparam int DUTY_FLOOR       = 29;
    localparam int DUTY_CEILING     = 971;
    localparam int DIV_STEPS        = 32;

    // control loop
    localparam int PULSE_CENTER_US  = 1500;
    localparam int OUT_LIMIT        = 200;
    localparam int REACH_TOL        = 4;

    // register byte offsets
    localparam logic [5:0] REG_CTRL     = 6'h00;
    localparam logic [5:0] REG_SETPOINT = 6'h04;
    localparam logic [5:0] REG_GAIN     = 6'h08;
    localparam logic [5:0] REG_OFFSET   = 6'h0c;
    localparam logic [5:0] REG_UNITS    = 6'h10;
    localparam logic [5:0] REG_STATUS   = 6'h14;
    localparam logic [5:0] REG_ABS      = 6'h18;
    localparam logic [5:0] REG_REV      = 6'h1c;
    localparam logic [5:0] REG_TURNS    = 6'h20;
    localparam logic [5:0] REG_SPEED    = 6'h24;
    localparam logic [5:0] REG_DUTY     = 6'h28;

    // reset values
    localparam logic [15:0] GAIN_RST    = 16'h0001;
    localparam logic [7:0]  OFFSET_RST  = 8'h1e;
    localparam logic [15:0] UNITS_RST   = 16'h0168;

    // status bit positions
    localparam int ST_BIT_REACHED = 0;
    localparam int ST_BIT_VALID   = 1;
    localparam int ST_BIT_REJECT  = 2;
endpackage

// >>> design/safc_top.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: run angle detection on every valid feedback cycle, far above quarter-turn rate
// RULE2: measure high and low time, reject pairs whose sum is outside the period window
// RULE3: angle is (units-1) minus (duty-29)*units/(971-29+1)
// RULE4: clamp the revolution angle into 0 to units-1
// RULE5: count turns up on wrap from high quadrant to low, down the other way
// RULE6: absolute angle built from signed turn count and revolution angle, 32-bit signed
// RULE7: previous angle takes the current angle at the end of each detection pass
// RULE8: error is setpoint minus absolute angle, multiplied by the proportional gain
// RULE9: proportional output saturates at plus or minus 200
// RULE10: push offset of plus or minus the tunable magnitude by error sign, zero otherwise
// RULE11: commanded speed is clamped output plus push offset
// RULE12: control pulse width is 1500 us plus the speed value
// RULE13: speeds within plus or minus 20 stop the servo; no feedback commands zero speed; the code does so only from reset until the first detection pass
// RULE14: control iteration and pulse width update repeat every 20 ms
// RULE15: target counts as reached when absolute error is at most 4
// RULE16: servo feedback is a 910 Hz pulse whose duty encodes shaft position
// RULE17: one high control pulse is sent every 20 ms
// RULE18: duty is 1000 times high time over period, integer tenths of percent
module safc_top
    import safc_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYCLES_DEF,
    parameter int FB_MIN_CYC   = FB_MIN_CYC_DEF,
    parameter int FB_MAX_CYC   = FB_MAX_CYC_DEF,
    parameter int US_CYCLES    = CYC_PER_US
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        feedback_in,
    output logic             control_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_DUTY, ST_ANGLE, ST_TRACK} safc_state_t;

    function automatic logic [31:0] safc_merge(input logic [31:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[8*i +: 8] = wdata[8*i +: 8];
        end
        return r;
    endfunction

    // ---------------- register bus ----------------
    logic               ctrl_enable;
    logic signed [31:0] setpoint_angle;
    logic signed [15:0] proportional_gain;
    logic        [7:0]  offset_mag;
    logic        [15:0] units_per_revolution;
    logic               reached;
    logic               fb_valid;
    logic               meas_reject;
    logic signed [31:0] abs_angle;
    logic        [15:0] rev_angle;
    logic        [15:0] previous_rev_angle;
    logic signed [31:0] turns;
    logic signed [31:0] speed;
    logic        [9:0]  duty;

    wire        bus_go   = avs_write & ~avs_waitrequest;
    wire [31:0] wr_merge = safc_merge(32'h0, avs_writedata, avs_byteenable);
    wire [31:0] rd_word  =
        (avs_address == REG_CTRL)     ? {31'h0, ctrl_enable} :
        (avs_address == REG_SETPOINT) ? setpoint_angle :
        (avs_address == REG_GAIN)     ? {16'h0, proportional_gain} :
        (avs_address == REG_OFFSET)   ? {24'h0, offset_mag} :
        (avs_address == REG_UNITS)    ? {16'h0, units_per_revolution} :
        (avs_address == REG_STATUS)   ? {29'h0, meas_reject, fb_valid, reached} :
        (avs_address == REG_ABS)      ? abs_angle :
        (avs_address == REG_REV)      ? {16'h0, rev_angle} :
        (avs_address == REG_TURNS)    ? turns :
        (avs_address == REG_SPEED)    ? speed :
        (avs_address == REG_DUTY)     ? {22'h0, duty} : 32'h0;
    wire [31:0] set_merge = safc_merge(setpoint_angle, avs_writedata, avs_byteenable);
    wire [31:0] gain_merge =
        safc_merge({16'h0, proportional_gain}, avs_writedata, avs_byteenable);
    wire [31:0] units_merge =
        safc_merge({16'h0, units_per_revolution}, avs_writedata, avs_byteenable);

    // one wait cycle per access; writes land at the edge that sees waitrequest low
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else if (ce) begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read & avs_waitrequest) avs_readdata <= rd_word;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_enable          <= 1'b0;
            setpoint_angle       <= 32'sh0;
            proportional_gain    <= GAIN_RST;
            offset_mag           <= OFFSET_RST;
            units_per_revolution <= UNITS_RST;
        end else if (ce && bus_go) begin
            if (avs_address == REG_CTRL && avs_byteenable[0]) ctrl_enable <= avs_writedata[0];
            if (avs_address == REG_SETPOINT) setpoint_angle <= set_merge;
            if (avs_address == REG_GAIN) proportional_gain <= gain_merge[15:0];
            if (avs_address == REG_OFFSET && avs_byteenable[0]) offset_mag <= wr_merge[7:0];
            if (avs_address == REG_UNITS) units_per_revolution <= units_merge[15:0];
        end
    end

    // ---------------- feedback measurement ----------------
    logic [1:0]  fb_sync;
    logic        fb_prev;
    logic [19:0] high_cnt;
    logic [19:0] low_cnt;
    logic [19:0] high_time;
    logic        have_high;
    logic        meas_ready;
    logic [19:0] meas_high;
    logic [20:0] meas_period;

    wire fb_rise = fb_sync[1] & ~fb_prev;
    wire fb_fall = ~fb_sync[1] & fb_prev;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fb_sync     <= 2'h0;
            fb_prev     <= 1'b0;
            high_cnt    <= 20'h0;
            low_cnt     <= 20'h0;
            high_time   <= 20'h0;
            have_high   <= 1'b0;
            meas_ready  <= 1'b0;
            meas_high   <= 20'h0;
            meas_period <= 21'h0;
        end else if (ce) begin
            fb_sync    <= {fb_sync[0], feedback_in};
            fb_prev    <= fb_sync[1];
            meas_ready <= 1'b0;
            if (fb_fall) begin
                high_time <= high_cnt;
                have_high <= 1'b1;
                high_cnt  <= 20'h0;
                low_cnt   <= 20'h1;
            end else if (fb_rise) begin
                meas_ready  <= have_high;                              // see RULE2
                meas_high   <= high_time;
                meas_period <= {1'b0, high_time} + {1'b0, low_cnt};    // see RULE2
                low_cnt     <= 20'h0;
                high_cnt    <= 20'h1;
            end else if (fb_sync[1]) begin
                if (~&high_cnt) high_cnt <= high_cnt + 20'h1;
            end else begin
                if (~&low_cnt) low_cnt <= low_cnt + 20'h1;
            end
        end
    end

    // ---------------- angle detection ----------------
    safc_state_t state;
    logic        duty_below;
    logic        div_done;
    logic [31:0] div_quot;

    wire meas_ok = meas_ready && meas_period >= 21'(FB_MIN_CYC)
                              && meas_period <= 21'(FB_MAX_CYC);         // see RULE2
    wire        in_idle    = state == ST_IDLE;
    wire [31:0] duty_num   = {12'h0, meas_high} * 32'(DUTY_SCALE);       // see RULE18
    wire        q_below    = div_quot < 32'(DUTY_FLOOR);
    wire [31:0] dc_dist    = q_below ? 32'(DUTY_FLOOR) - div_quot : div_quot - 32'(DUTY_FLOOR);
    wire [31:0] ang_num    = dc_dist * {16'h0, units_per_revolution};    // see RULE3
    wire [31:0] ang_den    = 32'(DUTY_CEILING - DUTY_FLOOR + 1);
    wire        div_start  = (in_idle & meas_ok) | (state == ST_DUTY & div_done);  // see RULE1
    wire [31:0] div_num    = in_idle ? duty_num : ang_num;
    wire [31:0] div_den    = in_idle ? {11'h0, meas_period} : ang_den;

    wire signed [31:0] units_s   = {16'h0, units_per_revolution};
    wire signed [31:0] q_s       = duty_below ? -$signed(div_quot) : $signed(div_quot);
    wire signed [31:0] theta_raw = units_s - 32'sd1 - q_s;                // see RULE3
    wire signed [31:0] theta_cl  = theta_raw < 32'sd0 ? 32'sd0 :
                                   theta_raw > units_s - 32'sd1 ? units_s - 32'sd1 :
                                   theta_raw;                             // see RULE4

    wire [15:0] q2_limit = units_per_revolution >> 2;
    wire [17:0] q3_wide  = ({2'h0, units_per_revolution} * 18'h3) >> 2;
    wire [15:0] q3_limit = q3_wide[15:0];
    wire wrap_up = fb_valid && rev_angle < q2_limit && previous_rev_angle > q3_limit;
    wire wrap_dn = fb_valid && previous_rev_angle < q2_limit && rev_angle > q3_limit;
    wire signed [31:0] next_turns = wrap_up ? turns + 32'sd1 :
                                    wrap_dn ? turns - 32'sd1 : turns;     // see RULE5
    wire signed [31:0] rev_s      = {16'h0, rev_angle};
    wire signed [31:0] next_abs   = (next_turns >= 32'sd0) ? next_turns * units_s + rev_s :
                                    (next_turns + 32'sd1) * units_s - (units_s - rev_s); // see RULE6

    safc_div u_div (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .start    (div_start),
        .dividend (div_num),
        .divisor  (div_den),
        .done     (div_done),
        .quotient (div_quot)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state              <= ST_IDLE;
            duty               <= 10'h0;
            duty_below         <= 1'b0;
            rev_angle          <= 16'h0;
            previous_rev_angle <= 16'h0;
            turns              <= 32'sh0;
            abs_angle          <= 32'sh0;
            fb_valid           <= 1'b0;
            meas_reject        <= 1'b0;
        end else if (ce) begin
            unique case (state)
                ST_IDLE: begin
                    if (meas_ok) state <= ST_DUTY;
                    if (meas_ready) meas_reject <= ~meas_ok;
                end
                ST_DUTY: if (div_done) begin
                    duty       <= div_quot[9:0];
                    duty_below <= q_below;
                    state      <= ST_ANGLE;
                end
                ST_ANGLE: if (div_done) begin
                    rev_angle <= theta_cl[15:0];
                    state     <= ST_TRACK;
                end
                ST_TRACK: begin
                    turns              <= next_turns;
                    abs_angle          <= next_abs;
                    previous_rev_angle <= rev_angle;                       // see RULE7
                    fb_valid           <= 1'b1;
                    state              <= ST_IDLE;
                end
            endcase
        end
    end

    // ---------------- control loop and pulse output ----------------
    logic [22:0] frame_cnt;
    logic [19:0] pulse_len;
    logic [19:0] pulse_cnt;

    wire               frame_tick     = frame_cnt == 23'(FRAME_CYCLES - 1);   // see RULE14
    wire signed [31:0] position_error = setpoint_angle - abs_angle;           // see RULE8
    wire signed [31:0] gain_ext       = {{16{proportional_gain[15]}}, proportional_gain};
    wire signed [31:0] p_out          = position_error * gain_ext;            // see RULE8
    wire signed [31:0] p_clamp        = p_out > OUT_LIMIT ? OUT_LIMIT :
                                        p_out < -OUT_LIMIT ? -OUT_LIMIT : p_out; // see RULE9
    wire signed [31:0] mag_s          = {24'h0, offset_mag};
    wire signed [31:0] push           = position_error > 32'sd0 ? mag_s :
                                        position_error < 32'sd0 ? -mag_s : 32'sd0; // see RULE10
    wire signed [31:0] next_speed     = fb_valid ? p_clamp + push : 32'sd0;   // see RULE11
    wire signed [31:0] width_us       = PULSE_CENTER_US + next_speed;          // see RULE12
    wire signed [31:0] width_cyc      = width_us * US_CYCLES;
    wire               next_reached   = fb_valid && position_error <= REACH_TOL
                                                 && position_error >= -REACH_TOL; // see RULE15

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_cnt   <= 23'h0;
            pulse_len   <= 20'h0;
            pulse_cnt   <= 20'h0;
            speed       <= 32'sh0;
            reached     <= 1'b0;
            control_out <= 1'b0;
        end else if (ce) begin
            frame_cnt <= frame_tick ? 23'h0 : frame_cnt + 23'h1;
            if (frame_tick) begin
                speed       <= next_speed;                                 // see RULE13
                reached     <= next_reached;
                pulse_len   <= width_cyc[19:0];
                pulse_cnt   <= 20'h0;
                control_out <= ctrl_enable;                                // see RULE17
            end else if (control_out) begin
                pulse_cnt <= pulse_cnt + 20'h1;
                if (pulse_cnt == pulse_len - 20'h1) control_out <= 1'b0;   // see RULE12
            end
        end
    end

    // ---------------- checks ----------------
    logic [19:0] high_len;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) high_len <= 20'h0;
        else if (ce) high_len <= control_out ? high_len + 20'h1 : 20'h0;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_track_step;
        ce && state == ST_TRACK;
    endsequence
    sequence s_frame;
        ce && frame_tick;
    endsequence

    chk_wrap_count_up: assert property ( // see RULE5
        s_track_step ##0 wrap_up |=> turns == $past(turns) + 32'sd1)
        else $error("turn count missed an upward wrap");
    chk_wrap_count_down: assert property ( // see RULE5
        s_track_step ##0 wrap_dn |=> turns == $past(turns) - 32'sd1)
        else $error("turn count missed a downward wrap");
    chk_prev_angle_copy: assert property ( // see RULE7
        s_track_step |=> previous_rev_angle == $past(rev_angle) && state == ST_IDLE)
        else $error("previous angle not updated after detection");
    chk_rev_angle_range: assert property ( // see RULE4
        s_track_step ##0 (units_per_revolution != 16'h0) |-> rev_angle < units_per_revolution)
        else $error("revolution angle outside range");
    chk_window_reject: assert property ( // see RULE2
        ce && in_idle && meas_ready && !meas_ok |=> state == ST_IDLE && meas_reject)
        else $error("out-of-window measurement was used");
    chk_frame_pulse: assert property ( // see RULE17
        s_frame ##0 ctrl_enable |=> control_out && pulse_cnt == 20'h0)
        else $error("no control pulse at frame start");
    chk_pulse_width: assert property ( // see RULE12
        $fell(control_out) |-> high_len == pulse_len)
        else $error("control pulse width differs from commanded width");
    chk_speed_band: assert property ( // see RULE11
        s_frame |=> speed <= OUT_LIMIT + $past(mag_s) && speed >= -(OUT_LIMIT + $past(mag_s)))
        else $error("commanded speed outside clamp plus push");
    chk_push_sign: assert property ( // see RULE10
        s_frame ##0 (fb_valid && position_error > 32'sd0 && proportional_gain >= 16'sd0)
        |=> speed >= $past(mag_s))
        else $error("positive error did not give positive push");
    chk_reach_flag: assert property ( // see RULE15
        s_frame ##0 (fb_valid && position_error <= REACH_TOL && position_error >= -REACH_TOL)
        |=> reached)
        else $error("reached flag missing inside tolerance");
    chk_stop_center: assert property ( // see RULE13
        s_frame ##0 !fb_valid |=> pulse_len == 20'(PULSE_CENTER_US * US_CYCLES))
        else $error("no-feedback pulse not at stop width");
endmodule

// >>> dv/safc_servo_model.sv
`timescale 1ns/1ps
module safc_servo_model (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic [9:0] duty_tenths,
    input  wire logic [7:0] period_cyc,
    output logic            feedback_in
);
    logic [7:0] phase;
    logic [7:0] high_len;
    wire  [7:0] next_high = 8'((int'(duty_tenths) * int'(period_cyc)) / 1000);
    wire        wrap      = phase + 8'h01 >= period_cyc;
    // high share of each period carries the shaft position
    // position taken once per period, so no cycle mixes two angles
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase    <= 8'h00;
            high_len <= 8'h00;
        end else begin
            phase <= wrap ? 8'h00 : phase + 8'h01;
            if (wrap) high_len <= next_high;
        end
    end
    assign feedback_in = arst_n && (phase < high_len);
endmodule

// >>> dv/safc_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module safc_tb_top;
    import safc_pkg::*;
    logic        core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
    logic        feedback_in, control_out, first_pass;
    logic [5:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rexp;
    logic [9:0]  duty;
    logic [7:0]  period;
    int          err_count, checks_done, fall_cnt, hw, turns, prev, abs_e, pexp;
    logic [31:0] rq[$];
    int          pq[$];
    int          steps[8] = '{500, 20, 900, 980, 100, 500, 900, 100};

    safc_top #(.FRAME_CYCLES(4000), .FB_MIN_CYC(90), .FB_MAX_CYC(110), .US_CYCLES(1)) safc_top_i (
        .core_clk, .arst_n, .ce(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .feedback_in, .control_out);
    safc_servo_model safc_servo_model_i (
        .core_clk, .arst_n, .duty_tenths(duty), .period_cyc(period), .feedback_in);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && rq.size() > 0) begin
            rexp = rq.pop_front();
            `CHK(avs_readdata, rexp)
        end
        if (control_out === 1'b1) hw++;
        else if (hw != 0) begin
            if (pq.size() > 0) begin
                pexp = pq.pop_front();
                `CHK(hw, pexp)
            end
            hw = 0;
            fall_cnt++;
        end
    end

    task automatic finish_test;
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) err_count++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic wait_fall;
        int c, n;
        c = fall_cnt;
        n = 0;
        while (fall_cnt == c && n < 10000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 10000) err_count++;
    endtask

    task automatic step(input int d);
        int r;
        duty <= 10'(d);
        repeat (400) @(posedge core_clk);
        r = 359 - ((d - 29) * 360) / 943;
        r = r < 0 ? 0 : (r > 359 ? 359 : r);
        if (!first_pass && r < 90 && prev > 270) turns++;
        else if (!first_pass && prev < 90 && r > 270) turns--;
        first_pass = 1'b0;
        prev = r;
        abs_e = turns >= 0 ? turns * 360 + r : (turns + 1) * 360 - (360 - r);
        rd(REG_REV, 32'(r));
        rd(REG_TURNS, 32'(turns));
        rd(REG_ABS, 32'(abs_e));
        rd(REG_DUTY, 32'(d));
    endtask

    task automatic pulse_case(input int rel, input int g, input int off);
        int s;
        s = rel * g;
        s = s > 200 ? 200 : (s < -200 ? -200 : s);
        s = s + (rel > 0 ? off : (rel < 0 ? -off : 0));
        bus(1'b1, REG_GAIN, 32'(g));
        bus(1'b1, REG_OFFSET, 32'(off));
        bus(1'b1, REG_SETPOINT, 32'(abs_e + rel));
        wait_fall;
        pq.push_back(1500 + s);
        wait_fall;
        rd(REG_SPEED, 32'(s));
        rd(REG_STATUS, 32'({1'b1, 1'(rel <= 4 && rel >= -4)}));
    endtask

    initial begin
        int c;
        arst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        duty = 10'd500;
        period = 8'd100;
        first_pass = 1'b1;
        void'($urandom(71));
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd(REG_STATUS, 32'h0);
        rd(REG_SPEED, 32'h0);
        rd(REG_GAIN, 32'h1);
        rd(REG_OFFSET, 32'h1e);
        rd(REG_UNITS, 32'h168);
        avs_byteenable <= 4'h2;
        bus(1'b1, REG_OFFSET, 32'h55);
        avs_byteenable <= 4'hf;
        rd(REG_OFFSET, 32'h1e);
        bus(1'b1, 6'h3c, 32'h5a5a);
        rd(6'h3c, 32'h0);
        foreach (steps[i]) step(steps[i]);
        bus(1'b1, REG_CTRL, 32'h1);
        pulse_case(1, 1, 30);
        pulse_case(4, 1, 30);
        pulse_case(-5, 1, 30);
        pulse_case(250, 1, 30);
        pulse_case(-300, 1, 30);
        pulse_case(70, 3, 10);
        pulse_case(int'($urandom % 500) - 250, 1, 30);
        pulse_case(0, 1, 30);
        period <= 8'd150;
        repeat (400) @(posedge core_clk);
        rd(REG_STATUS, 32'h7);
        rd(REG_REV, 32'(prev));
        period <= 8'd100;
        bus(1'b1, REG_CTRL, 32'h0);
        repeat (2000) @(posedge core_clk);
        c = fall_cnt;
        repeat (4100) @(posedge core_clk);
        `CHK(fall_cnt, c)
        period <= 8'd0;
        arst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4100) @(posedge core_clk);
        rd(REG_STATUS, 32'h0);
        rd(REG_SPEED, 32'h0);
        finish_test;
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        err_count++;
        finish_test;
    end
endmodule
